// ### hw/dgi_pkg.sv
package dgi_pkg;
  localparam logic [7:0] ADDR_GP_IN = 8'h05;
  localparam logic [7:0] ADDR_GP_OUT = 8'h06;
  localparam logic [7:0] ADDR_IDLE_LO = 8'h0D;
  localparam logic [7:0] ADDR_IDLE_HI = 8'h0E;
  localparam logic [7:0] ADDR_IDENT = 8'h1D;
  localparam logic [7:0] RST_IDLE_LO = 8'h83;
  localparam logic [1:0] RST_IDLE_HI = 2'h2;
  localparam logic [2:0] RST_GP_OUT = 3'h0;
  localparam logic [1:0] MODE_ASI = 2'h3;
  localparam logic [1:0] VARIANT_CODE = 2'h1;
  localparam int GPIO_COUNT = 3;
  localparam int IDENT_LOOP_BIT = 5;
  localparam int IDENT_MODE_LSB = 3;
  localparam logic [9:0] VALID_NONE = 10'h000;
  typedef enum logic [1:0] {DGI_STD_type_unused, DGI_ASI_type_unused} dgi_dummy_type;
  typedef enum {DGI_STREAM_VIDEO, DGI_STREAM_ASI} dgi_stream_type;
endpackage : dgi_pkg

// ### hw/dgi_gpio_if.sv
`timescale 1ns/1ps
interface dgi_gpio_if;
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;
  modport owner (output pin_raw, input pin_sync);
  modport sync (input pin_raw, output pin_sync);
endinterface : dgi_gpio_if

// ### hw/dgi_sync.sv
`timescale 1ns/1ps
module dgi_sync (
  input wire logic clk,
  input wire logic rst_n,
  dgi_gpio_if.sync gp
);
  logic [dgi_pkg::GPIO_COUNT-1:0] stage1;
  logic [dgi_pkg::GPIO_COUNT-1:0] stage2;
  genvar i;
  generate
    for (i = 0; i < dgi_pkg::GPIO_COUNT; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= gp.pin_raw[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate
  assign gp.pin_sync = stage2;
endmodule : dgi_sync

// ### hw/dgi_regs.sv
// What this block does
// R1 - Input register returns synchronised GPIO pin levels.
// R2 - Output register drives GPIO outputs, reads back.
// R3 - ASI mode inserts programmable idle character.
// R4 - Idle high register stores only two bits.
// R5 - Identity register returns read-only variant code.
// R6 - Identity bit five shows loop-through enable.
// R8 - Stream mode code 11 alone selects ASI.
// R9 - Reserved bits and addresses read zero.
`timescale 1ns/1ps
module dgi_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] gpio_in,
  output logic [2:0] general_output_select,
  input wire logic loop_en_pin,
  input wire logic [1:0] stream_mode,
  input wire logic [9:0] data_in,
  input wire logic data_valid,
  output logic [9:0] data_out,
  output logic asi_active,
  output logic loop_en
);
  dgi_gpio_if gp ();
  logic [7:0] idle_lo;
  logic [1:0] idle_hi;
  logic loop_s1;
  logic loop_s2;
  logic [1:0] mode_s1;
  logic [1:0] mode_s2;
  logic [7:0] next_rdata;
  logic [9:0] next_data_out;
  logic [9:0] idle_char;
  logic is_asi;
  logic wr_gp_out;
  logic wr_idle_lo;
  logic wr_idle_hi;

  assign gp.pin_raw = gpio_in;
  dgi_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .gp(gp)
  );

  assign wr_gp_out = reg_wr && (reg_addr == dgi_pkg::ADDR_GP_OUT);
  assign wr_idle_lo = reg_wr && (reg_addr == dgi_pkg::ADDR_IDLE_LO);
  assign wr_idle_hi = reg_wr && (reg_addr == dgi_pkg::ADDR_IDLE_HI);
  assign idle_char = {idle_hi, idle_lo};
  assign is_asi = (mode_s2 == dgi_pkg::MODE_ASI); // see R8

  // Read multiplexer; unmapped addresses return zero.
  always_comb begin
    next_rdata = 8'h00; // see R9
    case (reg_addr)
      dgi_pkg::ADDR_GP_IN: next_rdata = {5'h00, gp.pin_sync}; // see R1
      dgi_pkg::ADDR_GP_OUT: next_rdata = {5'h00, general_output_select}; // see R2
      dgi_pkg::ADDR_IDLE_LO: next_rdata = idle_lo;
      dgi_pkg::ADDR_IDLE_HI: next_rdata = {6'h00, idle_hi}; // see R4
      dgi_pkg::ADDR_IDENT: next_rdata = {2'h0, loop_s2, mode_s2, 1'b0,
        dgi_pkg::VARIANT_CODE}; // see R5 see R6
      default: next_rdata = 8'h00; // see R9
    endcase
  end

  // In ASI mode, idle character replaces the stream when no valid data is present.
  always_comb begin
    next_data_out = data_in;
    if (is_asi && !data_valid) begin
      next_data_out = idle_char; // see R3
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      general_output_select <= dgi_pkg::RST_GP_OUT;
      idle_lo <= dgi_pkg::RST_IDLE_LO;
      idle_hi <= dgi_pkg::RST_IDLE_HI;
    end else begin
      if (wr_gp_out) begin
        general_output_select <= reg_wdata[2:0]; // see R2
      end
      if (wr_idle_lo) begin
        idle_lo <= reg_wdata; // see R3
      end
      if (wr_idle_hi) begin
        idle_hi <= reg_wdata[1:0]; // see R4
      end
    end
  end

  // Pin levels pass two flip-flops before use.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_s1 <= 1'b0;
      loop_s2 <= 1'b0;
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
    end else begin
      loop_s1 <= loop_en_pin;
      loop_s2 <= loop_s1; // see R6
      mode_s1 <= stream_mode;
      mode_s2 <= mode_s1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      data_out <= dgi_pkg::VALID_NONE;
      asi_active <= 1'b0;
      loop_en <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      data_out <= next_data_out;
      asi_active <= is_asi;
      loop_en <= loop_s2;
    end
  end
endmodule : dgi_regs

// ### dv/dgi_regs_assertions.sv
`timescale 1ns/1ps
module dgi_regs_assertions (
  input wire logic clk, rst_n, reg_wr, data_valid, asi_active,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [2:0] general_output_select,
  input wire logic [1:0] stream_mode,
  input wire logic [9:0] data_in, data_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire wo = reg_wr && reg_addr == 8'h06;
  sequence s_asi;
    (stream_mode == 2'h3) [*4];
  endsequence
  sequence s_vid;
    (stream_mode != 2'h3) [*4];
  endsequence
  a_out_write: assert property (wo |=> general_output_select == $past(reg_wdata[2:0]))
    else $error("gp out");
  a_in_read: assert property (reg_addr == 8'h05 |=> reg_rdata[7:3] == 5'h00)
    else $error("gp in");
  a_hi_read: assert property (reg_addr == 8'h0E |=> reg_rdata[7:2] == 6'h00)
    else $error("idle hi");
  a_id_read: assert property (reg_addr == 8'h1D |=> reg_rdata[2:0] == 3'h1)
    else $error("ident");
  a_valid_pass: assert property (data_valid |=> data_out == $past(data_in))
    else $error("valid data");
  a_video_pass: assert property (s_vid |=> data_out == $past(data_in))
    else $error("video");
  a_asi_on: assert property (s_asi |-> asi_active)
    else $error("asi");
  a_gap_zero: assert property (reg_addr inside {[8'h07:8'h0C]} |=> reg_rdata == 8'h00)
    else $error("gap");
endmodule : dgi_regs_assertions
bind dgi_regs dgi_regs_assertions chk_u (.*);

// ### dv/dgi_pin_model.sv
`timescale 1ns/1ps
module dgi_pin_model (
  input wire logic [2:0] drive_lvl,
  output logic [2:0] gpio_in
);
  assign gpio_in = drive_lvl;
endmodule : dgi_pin_model

// ### dv/deserializer_gpio_idle_regs_test.sv
`timescale 1ns/1ps
module deserializer_gpio_idle_regs_test;
  logic clk = 0, rst_n = 0, wr = 0, lp = 1, dv = 0, asi, le;
  logic [7:0] a = 0, wd = 0, rd;
  logic [2:0] gi, go;
  logic [1:0] md = 0;
  logic [9:0] di = 10'h155, dq;
  int n_errors = 0, n_tests = 0;
  dgi_pin_model pm_u (.drive_lvl(3'h5), .gpio_in(gi));
  dgi_regs dut_u (.clk, .rst_n, .reg_addr(a), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rd),
    .gpio_in(gi), .general_output_select(go), .loop_en_pin(lp), .stream_mode(md),
    .data_in(di), .data_valid(dv), .data_out(dq), .asi_active(asi), .loop_en(le));
  initial forever #50 clk = ~clk;
  task cyc;
    @(posedge clk) #1;
  endtask : cyc
  task chk(input logic [9:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask : chk
  task rw(input logic [7:0] ad, d, input logic w);
    {a, wd, wr} = {ad, d, w};
    cyc;
    wr = 0;
  endtask : rw
  task t_regs;
    rw(8'h0D, 0, 0);
    chk(rd, 10'h083);
    rw(8'h0E, 8'hFF, 1);
    rw(8'h0E, 0, 0);
    chk(rd, 10'h003);
    rw(8'h06, 8'hFF, 1);
    chk(go, 10'h007);
    rw(8'h06, 0, 0);
    chk(rd, 10'h007);
    rw(8'h05, 8'hFF, 1);
    chk(rd, 10'h005);
    chk(go, 10'h007);
    rw(8'h10, 0, 0);
    chk(rd, 10'h000);
  endtask : t_regs
  task t_reset;
    rst_n = 0;
    cyc;
    chk(go, 10'h000);
    chk(dq, 10'h000);
    rst_n = 1;
    rw(8'h0D, 0, 0);
    chk(rd, 10'h083);
    rw(8'h0E, 0, 0);
    chk(rd, 10'h002);
    rw(8'h1D, 0, 0);
    chk(rd, {2'h0, lp, md, 3'h1});
    chk(le, lp);
  endtask : t_reset
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      {md, lp} = {m[1:0], m[0]};
      repeat (4) cyc;
      chk(asi, m == 3);
      chk(dq, m == 3 ? 10'h383 : di);
      rw(8'h1D, 0, 0);
      chk(rd, {2'h0, lp, md, 3'h1});
      chk(le, lp);
    end
    dv = 1;
    cyc;
    chk(dq, di);
  endtask : t_modes
  task report_and_stop;
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) cyc;
    rst_n = 1;
    t_regs;
    t_modes;
    t_reset;
    report_and_stop;
  end
endmodule : deserializer_gpio_idle_regs_test
